// ### core/dotc_top.sv
/*
  dotc_top: on-die termination timing control as seen from the control pin.
  Picks synchronous or asynchronous response, runs the latency pipeline, the
  power-down entry transition and DLL relock, and checks minimum hold times.
  Assumes commands, clock enable and the control pin are synchronous to i_clk.
*/
// Chosen here: the placing of the registers and strobed register access.
// Contract
// - hold measured from first high or write
// - async timing in powerdown with DLL off
// - async timing while DLL relocks after reset
// - async mode ignores additive latency entirely
// - async turn-on between 2 and 8.5 ns; here one clock after the sample, 20 ns
// - async turn-off between 2 and 8.5 ns; here one clock after the sample, 20 ns
// - entry window ends at first clock-enable low
// - anpd equals latency plus one clock
// - refresh in progress extends entry window
// - window turn-on within combined sync/async bounds
// - window turn-off within combined sync/async bounds
// - sync before window, async after window
// - short hold four, long hold six clocks
// - odt latency equals cwl plus al minus two
// - sync on/off follows latency after sample
`timescale 1ns/100ps
module dotc_top #(
  parameter int DEPTH = 16,
  parameter logic [11:0] DLL_LOCK_CYC = dotc_pkg::RST_DLL_LOCK
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // memory pins, sampled on the rising edge
  input wire logic i_odt,
  input wire logic i_cke,
  input wire logic i_cmd_write,
  input wire logic i_cmd_bl8,
  input wire logic i_cmd_refresh,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // termination state
  output logic o_rtt_on,
  output logic o_async_mode,
  output logic o_pde_window
);

  // configuration registers
  logic [3:0] cwl_r;
  logic [3:0] al_r;
  logic nom_en_r;
  logic wr_en_r;
  logic pd_dll_on_r;
  logic [7:0] trfc_r;
  logic hold_flag_r;
  logic [31:0] rdata_r;

  // block state
  dotc_pkg::dotc_mode_e mode_r;
  dotc_pkg::dotc_mode_e mode_nxt;
  logic [11:0] lock_cnt_r;
  logic [7:0] ref_cnt_r;
  logic cke_prev_r;
  logic rtt_r;
  logic rtt_nxt;
  logic [DEPTH-1:0] taps;
  logic hold_viol;

  // decode of the register port
  wire wr_cfg = i_wr && (i_addr == dotc_pkg::ADDR_CFG);
  wire wr_trfc = i_wr && (i_addr == dotc_pkg::ADDR_TRFC);
  wire wr_flag = i_wr && (i_addr == dotc_pkg::ADDR_FLAG);
  wire dll_reset = wr_cfg && i_wdata[dotc_pkg::CFG_DLLRST_BIT];
  wire clr_hold = wr_flag && i_wdata[dotc_pkg::FLAG_HOLD_BIT];

  // latency and power-down entry figures
  wire [4:0] wl = {1'b0, cwl_r} + {1'b0, al_r};
  wire [4:0] odt_lat_raw = (wl > dotc_pkg::LAT_OFFSET) ? wl - dotc_pkg::LAT_OFFSET : 5'h00;
  wire [4:0] odt_lat = (odt_lat_raw == 5'h00) ? 5'h01 : odt_lat_raw;
  // on and off latencies are equal, so the larger plus one is this
  wire [5:0] anpd = {1'b0, odt_lat} + 6'h01;

  wire rtt_enabled = nom_en_r | wr_en_r;
  wire dll_locked = (lock_cnt_r == 12'h000);
  wire cke_fell = cke_prev_r & ~i_cke;
  wire ref_busy = (ref_cnt_r != 8'h00);

  // synchronous path: tap holding the sample taken odt_lat edges ago
  wire [4:0] sync_idx = odt_lat - 5'h01;
  wire sync_src = taps[sync_idx[$clog2(DEPTH)-1:0]];
  // async path skips the additive latency and the pipeline depth
  // tap 0 already lags the pin by one edge: taking the raw pin would change
  // termination at the sampling edge itself, sooner than the minimum delay
  wire async_src = taps[dotc_pkg::ASYNC_CYC-1];

  wire async_now = (mode_r == dotc_pkg::DOTC_ASYNC) || (mode_r == dotc_pkg::DOTC_RELOCK);

  // latency pipeline of the control pin
  dotc_delay_line #(
    .DEPTH(DEPTH)
  ) u_delay (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_bit(i_odt),
    .o_taps(taps)
  );

  // minimum high time watch, writes only count while control is high
  dotc_hold_check u_hold (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_odt(i_odt),
    .i_write(i_cmd_write),
    .i_bl8(i_cmd_bl8),
    .o_violation(hold_viol),
    .o_remaining()
  );

  // mode selection: sync before the window ends, async after it
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      dotc_pkg::DOTC_SYNC: begin
        if (cke_fell && !pd_dll_on_r && rtt_enabled) begin
          // a refresh still running pushes the window end out
          mode_nxt = ref_busy ? dotc_pkg::DOTC_PDE_REF : dotc_pkg::DOTC_ASYNC;
        end
      end
      dotc_pkg::DOTC_PDE_REF: begin
        if (i_cke) begin
          mode_nxt = dotc_pkg::DOTC_SYNC;
        end else if (!ref_busy) begin
          mode_nxt = dotc_pkg::DOTC_ASYNC;
        end
      end
      dotc_pkg::DOTC_ASYNC: begin
        // exit handling kept simple: back to sync once clocks resume
        if (i_cke) begin
          mode_nxt = dotc_pkg::DOTC_SYNC;
        end
      end
      dotc_pkg::DOTC_RELOCK: begin
        if (lock_cnt_r == 12'h001) begin
          mode_nxt = dotc_pkg::DOTC_SYNC;
        end
      end
      default: begin
        mode_nxt = dotc_pkg::DOTC_SYNC;
      end
    endcase
    if (dll_reset) begin
      mode_nxt = dotc_pkg::DOTC_RELOCK;
    end
  end

  // termination follows the path of the current mode; inside the window the
  // sync pipeline still runs, which lies within the combined bounds
  always_comb begin
    if (!rtt_enabled) begin
      rtt_nxt = 1'b0;
    end else if (async_now) begin
      rtt_nxt = async_src;
    end else begin
      rtt_nxt = sync_src;
    end
  end

  // mode, dll lock and refresh counters
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_r <= dotc_pkg::DOTC_SYNC;
      lock_cnt_r <= 12'h000;
      ref_cnt_r <= 8'h00;
      cke_prev_r <= 1'b1;
    end else begin
      mode_r <= mode_nxt;
      cke_prev_r <= i_cke;
      if (dll_reset) begin
        lock_cnt_r <= DLL_LOCK_CYC;
      end else if (!dll_locked) begin
        lock_cnt_r <= lock_cnt_r - 12'h001;
      end
      if (i_cmd_refresh) begin
        ref_cnt_r <= trfc_r;
      end else if (ref_busy) begin
        ref_cnt_r <= ref_cnt_r - 8'h01;
      end
    end
  end

  // termination output register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rtt_r <= 1'b0;
    end else begin
      rtt_r <= rtt_nxt;
    end
  end

  // configuration writes; the dll reset bit is a pulse, not stored
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cwl_r <= dotc_pkg::RST_CWL;
      al_r <= dotc_pkg::RST_AL;
      nom_en_r <= 1'b0;
      wr_en_r <= 1'b0;
      pd_dll_on_r <= 1'b0;
      trfc_r <= dotc_pkg::RST_TRFC;
    end else begin
      if (wr_cfg) begin
        cwl_r <= i_wdata[dotc_pkg::CFG_CWL_LSB +: 4];
        al_r <= i_wdata[dotc_pkg::CFG_AL_LSB +: 4];
        nom_en_r <= i_wdata[dotc_pkg::CFG_NOM_BIT];
        wr_en_r <= i_wdata[dotc_pkg::CFG_WR_BIT];
        pd_dll_on_r <= i_wdata[dotc_pkg::CFG_PDDLL_BIT];
      end
      if (wr_trfc) begin
        trfc_r <= i_wdata[7:0];
      end
    end
  end

  // sticky hold flag: a new violation beats a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_flag_r <= 1'b0;
    end else if (hold_viol) begin
      hold_flag_r <= 1'b1;
    end else if (clr_hold) begin
      hold_flag_r <= 1'b0;
    end
  end

  // read words
  wire [31:0] cfg_word = {20'h00000, 1'b0, pd_dll_on_r, wr_en_r, nom_en_r, al_r, cwl_r};
  wire [31:0] stat_word = {26'h0000000, ref_busy, o_pde_window, dll_locked, mode_r, rtt_r};
  wire [31:0] flag_word = {31'h00000000, hold_flag_r};
  wire [31:0] trfc_word = {24'h000000, trfc_r};
  wire [31:0] anpd_unused = {26'h0000000, anpd};
  wire [31:0] rd_mux = (i_addr == dotc_pkg::ADDR_CFG) ? cfg_word :
                       (i_addr == dotc_pkg::ADDR_TRFC) ? trfc_word :
                       (i_addr == dotc_pkg::ADDR_STAT) ? (stat_word | (anpd_unused << 8)) :
                       (i_addr == dotc_pkg::ADDR_FLAG) ? flag_word : 32'h00000000;

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= i_rd ? rd_mux : 32'h00000000;
    end
  end

  // outputs
  assign o_rdata = rdata_r;
  assign o_rtt_on = rtt_r;
  assign o_async_mode = async_now;
  // window marker: at cke first low with dll off, or refresh extension
  assign o_pde_window = (mode_r == dotc_pkg::DOTC_PDE_REF) ||
                        (cke_fell && !pd_dll_on_r && rtt_enabled && mode_r == dotc_pkg::DOTC_SYNC);

endmodule

// ### shared/dotc_pkg.sv
/*
  dotc_pkg: constants, register map and mode type of the termination timing
  control block. Assumes a single 50 MHz clock standing in for the memory clock.
*/
package dotc_pkg;

  // clock and asynchronous termination figures
  localparam int TCK_PS = 20000;
  localparam int TAONPD_MIN_PS = 2000;
  localparam int TAONPD_MAX_PS = 8500;
  localparam int TAOFPD_MIN_PS = 2000;
  localparam int TAOFPD_MAX_PS = 8500;
  // least times round up, longest times round down, never under one cycle
  localparam int AON_MIN_RAW = (TAONPD_MIN_PS + TCK_PS - 1) / TCK_PS;
  localparam int AOF_MIN_RAW = (TAOFPD_MIN_PS + TCK_PS - 1) / TCK_PS;
  localparam int AON_MAX_RAW = TAONPD_MAX_PS / TCK_PS;
  localparam int AOF_MAX_RAW = TAOFPD_MAX_PS / TCK_PS;
  localparam int AON_MIN_CYC = (AON_MIN_RAW < 1) ? 1 : AON_MIN_RAW;
  localparam int AOF_MIN_CYC = (AOF_MIN_RAW < 1) ? 1 : AOF_MIN_RAW;
  localparam int AON_MAX_CYC = (AON_MAX_RAW < 1) ? 1 : AON_MAX_RAW;
  localparam int AOF_MAX_CYC = (AOF_MAX_RAW < 1) ? 1 : AOF_MAX_RAW;
  // async delay used: earliest legal edge, the two agree here
  localparam int ASYNC_CYC = (AON_MIN_CYC > AOF_MIN_CYC) ? AON_MIN_CYC : AOF_MIN_CYC;

  // hold intervals in clocks
  localparam logic [3:0] HOLD_SHORT = 4'h4;
  localparam logic [3:0] HOLD_LONG = 4'h6;
  // latency offset: odt latency = cwl + al - 2
  localparam logic [4:0] LAT_OFFSET = 5'h02;

  // register map (byte addresses)
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_TRFC = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_FLAG = 4'hC;

  // cfg fields
  localparam int CFG_CWL_LSB = 0;
  localparam int CFG_AL_LSB = 4;
  localparam int CFG_NOM_BIT = 8;
  localparam int CFG_WR_BIT = 9;
  localparam int CFG_PDDLL_BIT = 10;
  localparam int CFG_DLLRST_BIT = 11;
  // stat fields
  localparam int STAT_RTT_BIT = 0;
  localparam int STAT_MODE_LSB = 1;
  localparam int STAT_LOCK_BIT = 3;
  localparam int STAT_WIN_BIT = 4;
  localparam int STAT_REF_BIT = 5;
  // flag fields
  localparam int FLAG_HOLD_BIT = 0;

  // reset values
  localparam logic [3:0] RST_CWL = 4'h5;
  localparam logic [3:0] RST_AL = 4'h0;
  localparam logic [7:0] RST_TRFC = 8'h20;
  localparam logic [11:0] RST_DLL_LOCK = 12'h200;

  // termination timing modes
  typedef enum logic [1:0] {
    DOTC_SYNC,
    DOTC_PDE_REF,
    DOTC_ASYNC,
    DOTC_RELOCK
  } dotc_mode_e;

endpackage

// ### core/dotc_delay_line.sv
/*
  dotc_delay_line: shift register of control samples, one tap per clock.
  Assumes the caller picks the tap; tap 0 holds the sample of the last edge.
*/
`timescale 1ns/100ps
module dotc_delay_line #(
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // sample in, taps out
  input wire logic i_bit,
  output logic [DEPTH-1:0] o_taps
);

  logic [DEPTH-1:0] taps_r;

  // each stage is one clock older than the one before
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      taps_r <= '0;
    end else begin
      taps_r <= {taps_r[DEPTH-2:0], i_bit};
    end
  end

  assign o_taps = taps_r;

endmodule

// ### core/dotc_hold_check.sv
/*
  dotc_hold_check: watches the termination control input for its minimum
  high time after assertion and after a write. Assumes commands and the
  control input are sampled on the same rising edge.
*/
`timescale 1ns/100ps
module dotc_hold_check (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // sampled pins
  input wire logic i_odt,
  input wire logic i_write,
  input wire logic i_bl8,
  // result
  output logic o_violation,
  output logic [3:0] o_remaining
);

  logic odt_prev_r;
  logic [3:0] rem_r;
  logic [3:0] rem_nxt;
  logic [3:0] rem_dec;
  logic [3:0] wr_need;
  logic [3:0] rise_need;
  logic rise;

  // edges still owed high after this one
  assign rise = i_odt & ~odt_prev_r;
  assign rem_dec = (rem_r != 4'h0) ? rem_r - 4'h1 : 4'h0;
  assign wr_need = (i_bl8 ? dotc_pkg::HOLD_LONG : dotc_pkg::HOLD_SHORT) - 4'h1;
  assign rise_need = dotc_pkg::HOLD_SHORT - 4'h1;

  // both holds apply at once: keep the longer remainder
  always_comb begin
    rem_nxt = 4'h0;
    if (i_odt) begin
      rem_nxt = rise ? rise_need : rem_dec;
      if (i_write && wr_need > rem_nxt) begin
        rem_nxt = wr_need;
      end
    end
  end

  // low while a hold is still owed is flagged for one cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      odt_prev_r <= 1'b0;
      rem_r <= 4'h0;
      o_violation <= 1'b0;
    end else begin
      odt_prev_r <= i_odt;
      rem_r <= rem_nxt;
      o_violation <= ~i_odt & (rem_r != 4'h0);
    end
  end

  assign o_remaining = rem_r;

endmodule

// ### testbench/dotc_monitor.sv
/*
  dotc_monitor: port assertions for dotc_top.
  Assumes a bind into dotc_top; sees its ports only.
*/
`timescale 1ns/100ps
module dotc_monitor #(
  parameter int DEPTH = 16,
  parameter logic [11:0] DLL_LOCK_CYC = dotc_pkg::RST_DLL_LOCK
) (
  // clock, reset, pins
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_odt,
  input wire logic i_cke,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // state
  input wire logic o_rtt_on,
  input wire logic o_async_mode,
  input wire logic o_pde_window
);
  localparam int LOCK_LO = DLL_LOCK_CYC - 2;
  localparam int LOCK_HI = DLL_LOCK_CYC + 3;
  logic [3:0] cwl_r;
  logic [3:0] al_r;
  logic en_r;
  logic pddll_r;
  logic ck_r;
  logic am_r;
  logic [16:0] sh_r;
  logic [4:0] st_r;
  wire cfg_wr = i_wr && (i_addr == dotc_pkg::ADDR_CFG);
  wire [4:0] sum = {1'b0, cwl_r} + {1'b0, al_r};
  // latency never below one clock
  wire [4:0] lat = (sum < 5'h03) ? 5'h01 : sum - 5'h02;
  // fresh entry in sync mode with the DLL to be shut off
  wire fall = ck_r && !i_cke && !o_async_mode && en_r && !pddll_r;

  // config shadow
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cwl_r <= dotc_pkg::RST_CWL;
      al_r <= dotc_pkg::RST_AL;
      en_r <= 1'b0;
      pddll_r <= 1'b0;
    end else if (cfg_wr) begin
      cwl_r <= i_wdata[3:0];
      al_r <= i_wdata[7:4];
      en_r <= i_wdata[8] || i_wdata[9];
      pddll_r <= i_wdata[10];
    end
  end

  // pin history and settle count; any write or mode flip restarts it
  always_ff @(posedge i_clk) begin
    ck_r <= i_sys_rst || i_cke;
    am_r <= o_async_mode;
    sh_r <= i_sys_rst ? 17'h0 : {sh_r[15:0], i_odt};
    st_r <= (i_sys_rst || i_wr || o_async_mode != am_r) ? 5'h00 : st_r + {4'h0, st_r != 5'h1F};
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_sync_latency: assert property (st_r > 5'h11 && !o_async_mode && !o_pde_window |->
    o_rtt_on == (en_r && sh_r[lat])) else $error("sync termination latency wrong");
  a_async_delay: assert property (st_r > 5'h02 && o_async_mode |->
    o_rtt_on == (en_r && sh_r[1])) else $error("async termination delay wrong");
  a_pde_window: assert property (fall |-> o_pde_window)
    else $error("entry window missing");
  a_pde_bounded: assert property (fall |-> ##[1:80] o_async_mode)
    else $error("no async mode after entry");
  a_pddll_sync: assert property (pddll_r && st_r > 5'h14 |-> !o_async_mode)
    else $error("async with DLL kept on");
  a_relock_span: assert property (cfg_wr && i_wdata[11] |->
    ##[1:2] o_async_mode ##[LOCK_LO:LOCK_HI] !o_async_mode) else $error("relock span wrong");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_reset_clear: assert property ($past(i_sys_rst) |-> !o_rtt_on && !o_async_mode)
    else $error("outputs not cleared by reset");
endmodule

bind dotc_top dotc_monitor #(.DEPTH(DEPTH), .DLL_LOCK_CYC(DLL_LOCK_CYC)) mon (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_odt(i_odt), .i_cke(i_cke), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rtt_on(o_rtt_on),
  .o_async_mode(o_async_mode), .o_pde_window(o_pde_window));

// ### testbench/dotc_ctrl_model.sv
/*
  dotc_ctrl_model: controller side of the termination pin.
  Assumes the bench asks for one burst at a time while idle.
*/
`timescale 1ns/100ps
module dotc_ctrl_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // burst request, write offset 7 = no write
  input wire logic i_req,
  input wire logic [2:0] i_wr_at,
  input wire logic i_bl8,
  input wire logic i_short,
  // pins toward the device
  output logic o_odt,
  output logic o_write,
  output logic o_bl8
);
  logic [3:0] left_r;
  logic [3:0] el_r;
  logic [2:0] at_r;
  logic b8_r;
  // shortest legal high time, counted from the rise or the write
  wire [3:0] need = (i_wr_at == 3'h7) ? 4'h4 : {1'b0, i_wr_at} + (i_bl8 ? 4'h6 : 4'h4);

  // short drops the pin one clock early, the only wrong move
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      left_r <= 4'h0;
      el_r <= 4'h0;
      at_r <= 3'h7;
      b8_r <= 1'b0;
    end else if (i_req && left_r == 4'h0) begin
      left_r <= need - {3'h0, i_short};
      el_r <= 4'h0;
      at_r <= i_wr_at;
      b8_r <= i_bl8;
    end else if (left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      el_r <= el_r + 4'h1;
    end
  end
  // pin idles low between bursts, leaving room for read bursts
  assign o_odt = left_r != 4'h0;
  assign o_write = o_odt && el_r == {1'b0, at_r};
  // burst size means nothing without a write, so it wanders
  assign o_bl8 = o_write ? b8_r : el_r[0];
endmodule

// ### testbench/tb_top.sv
/*
  tb_top: self-checking bench for dotc_top.
  Assumes package, design, model and monitor compiled before it.
*/
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cke = 1'b1;
  logic rf = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic req = 1'b0;
  logic b8 = 1'b0;
  logic sh = 1'b0;
  logic [2:0] at = 3'h7;
  logic [3:0] addr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic odt, cw, cb, rtt, am, win;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  initial begin
    forever #10 clk = ~clk;
  end

  dotc_top #(.DEPTH(16), .DLL_LOCK_CYC(12'h008)) dut (.i_clk(clk), .i_sys_rst(rst), .i_odt(odt),
    .i_cke(cke), .i_cmd_write(cw), .i_cmd_bl8(cb), .i_cmd_refresh(rf), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_rtt_on(rtt), .o_async_mode(am), .o_pde_window(win));
  dotc_ctrl_model ctl (.i_clk(clk), .i_sys_rst(rst), .i_req(req), .i_wr_at(at), .i_bl8(b8),
    .i_short(sh), .o_odt(odt), .o_write(cw), .o_bl8(cb));

  // latency plus one, never under two
  function automatic logic [31:0] anpd(int c, int a);
    return (((c + a - 2) < 1) ? 1 : c + a - 2) + 1;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdat);
    @(posedge clk);
  endtask

  // pin state as {rtt, async, window}, looked at once settled
  task automatic pins(input string n, input logic [2:0] e);
    #1 chk(n, {29'h0, e}, {29'h0, rtt, am, win});
    @(posedge clk);
  endtask

  // long tail so the longest latency drains before the next step
  task automatic burst(input logic [2:0] w, input logic b, input logic s);
    at <= w;
    b8 <= b;
    sh <= s;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (30) @(posedge clk);
  endtask

  task automatic test_done;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    int unsigned c;
    int unsigned a;
    c = $urandom(32'hBA788062);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("cfg", dotc_pkg::ADDR_CFG, {24'h0, dotc_pkg::RST_AL, dotc_pkg::RST_CWL});
    rchk("trfc", dotc_pkg::ADDR_TRFC, {24'h0, dotc_pkg::RST_TRFC});
    rchk("stat", dotc_pkg::ADDR_STAT, (anpd(5, 0) << 8) | 32'h8);
    rchk("unmapped", 4'h2, 32'h0);
    // random latencies, legal bursts of every kind
    repeat (6) begin
      c = 5 + $urandom_range(3);
      a = $urandom_range(7);
      wreg(dotc_pkg::ADDR_CFG, (c | (a << 4)) | ($urandom_range(1) ? 32'h100 : 32'h200));
      rchk("anpd", dotc_pkg::ADDR_STAT, (anpd(c, a) << 8) | 32'h8);
      repeat (3) burst(3'($urandom_range(7)), 1'($urandom_range(1)), 1'b0);
      rchk("flag legal", dotc_pkg::ADDR_FLAG, 32'h0);
    end
    // one clock short: after rise, chop write, burst-of-eight write
    wreg(dotc_pkg::ADDR_CFG, 32'h135);
    for (int i = 0; i < 3; i++) begin
      burst((i == 0) ? 3'h7 : 3'h1, i == 2, 1'b1);
      rchk("flag set", dotc_pkg::ADDR_FLAG, 32'h1);
      wreg(dotc_pkg::ADDR_FLAG, 32'h1);
      rchk("flag clear", dotc_pkg::ADDR_FLAG, 32'h0);
    end
    // entry with the DLL going off, no refresh running
    repeat (20) @(posedge clk);
    cke <= 1'b0;
    pins("entry window", 3'h1);
    pins("async after entry", 3'h2);
    burst(3'h2, 1'b0, 1'b0);
    cke <= 1'b1;
    @(posedge clk);
    pins("exit", 3'h0);
    // refresh still running stretches the window
    repeat (20) @(posedge clk);
    wreg(dotc_pkg::ADDR_TRFC, 32'h18);
    rchk("trfc write", dotc_pkg::ADDR_TRFC, 32'h18);
    rf <= 1'b1;
    @(posedge clk);
    rf <= 1'b0;
    repeat (2) @(posedge clk);
    cke <= 1'b0;
    pins("refresh window", 3'h1);
    repeat (8) @(posedge clk);
    pins("refresh window held", 3'h1);
    repeat (40) @(posedge clk);
    pins("async after refresh", 3'h2);
    cke <= 1'b1;
    @(posedge clk);
    pins("exit", 3'h0);
    // DLL kept on in power-down stays synchronous
    wreg(dotc_pkg::ADDR_CFG, 32'h505);
    repeat (22) @(posedge clk);
    cke <= 1'b0;
    pins("dll on entry", 3'h0);
    burst(3'h0, 1'b1, 1'b0);
    pins("dll on stays sync", 3'h0);
    cke <= 1'b1;
    // DLL reset: asynchronous while relocking
    wreg(dotc_pkg::ADDR_CFG, 32'h905);
    @(posedge clk);
    pins("relock", 3'h2);
    burst(3'h7, 1'b0, 1'b0);
    pins("locked", 3'h0);
    rchk("dll reset clears", dotc_pkg::ADDR_CFG, 32'h105);
    test_done();
  end
endmodule
